// >>> sram_tap_instruction_logic.sv
// scan port controller with instruction register and data register selection
`timescale 1ns/100ps
`include "sram_tap_defs.svh"
module sram_tap_instruction_logic
    import sram_tap_pkg::*;
#(
    parameter int                   BSR_LEN   = 8,
    parameter logic [BSR_LEN-1:0]   PIN_MASK  = 8'h3f,
    parameter logic [BSR_LEN-1:0]   DEFAULTS  = 8'hff,
    // arbitrary identification value; bit 0 set as scan convention needs
    parameter logic [`ID_WIDTH-1:0] ID_VALUE  = 32'h0000_0001
) (
    input  wire logic               clk,
    input  wire logic               rst,
    input  wire logic               ce,
    input  wire logic               tck,
    input  wire logic               tms,
    input  wire logic               tdi,
    input  wire logic [BSR_LEN-1:0] pin_in,
    output logic                    tdo,
    output logic                    tdo_oe_n,
    output logic      [BSR_LEN-1:0] pin_out,
    output logic                    pin_drive,
    output logic                    pin_float,
    output logic      [`IR_WIDTH-1:0] active_instr
);

    // pin synchronisers; stage one is read only by stage two
    logic               tck_s1, tck_s2, tck_d;
    logic               tms_s1, tms_s2;
    logic               tdi_s1, tdi_s2;
    logic [BSR_LEN-1:0] pin_s1, pin_s2;

    always_ff @(posedge clk) begin
        if (rst) begin
            tck_s1 <= 1'b0;
            tck_s2 <= 1'b0;
            tck_d  <= 1'b0;
            tms_s1 <= 1'b1;
            tms_s2 <= 1'b1;
            tdi_s1 <= 1'b1;
            tdi_s2 <= 1'b1;
            pin_s1 <= '0;
            pin_s2 <= '0;
        end else if (ce) begin
            tck_s1 <= tck;
            tck_s2 <= tck_s1;
            tck_d  <= tck_s2;
            tms_s1 <= tms;
            tms_s2 <= tms_s1;
            tdi_s1 <= tdi;
            tdi_s2 <= tdi_s1;
            pin_s1 <= pin_in;
            pin_s2 <= pin_s1;
        end
    end

    wire tck_rise = tck_s2 & ~tck_d;
    wire tck_fall = ~tck_s2 & tck_d;

    // controller
    tap_state_type state, next_state;

    always_comb begin
        next_state = state;
        case (state)
            test_logic_reset: next_state = tms_s2 ? test_logic_reset : run_test_idle;
            run_test_idle:    next_state = tms_s2 ? select_dr : run_test_idle;
            select_dr:        next_state = tms_s2 ? select_ir : capture_dr;
            capture_dr:       next_state = tms_s2 ? exit1_dr : shift_dr;
            shift_dr:         next_state = tms_s2 ? exit1_dr : shift_dr;
            exit1_dr:         next_state = tms_s2 ? update_dr : pause_dr;
            pause_dr:         next_state = tms_s2 ? exit2_dr : pause_dr;
            exit2_dr:         next_state = tms_s2 ? update_dr : shift_dr;
            update_dr:        next_state = tms_s2 ? select_dr : run_test_idle;
            select_ir:        next_state = tms_s2 ? test_logic_reset : capture_ir;
            capture_ir:       next_state = tms_s2 ? exit1_ir : shift_ir;
            shift_ir:         next_state = tms_s2 ? exit1_ir : shift_ir;
            exit1_ir:         next_state = tms_s2 ? update_ir : pause_ir;
            pause_ir:         next_state = tms_s2 ? exit2_ir : pause_ir;
            exit2_ir:         next_state = tms_s2 ? update_ir : shift_ir;
            update_ir:        next_state = tms_s2 ? select_dr : run_test_idle;
            default:          next_state = test_logic_reset;
        endcase
    end

    // no test reset pin: power-up reset, or five tms-high edges, lands here
    always_ff @(posedge clk) begin
        if (rst) begin
            state <= test_logic_reset;
        end else if (ce && tck_rise) begin
            state <= next_state;
        end
    end

    // instruction register
    logic [`IR_WIDTH-1:0] ir_shift;
    logic [`IR_WIDTH-1:0] ir_active;

    wire in_tlr       = state == test_logic_reset;
    wire do_cap_ir    = tck_rise && state == capture_ir;
    wire do_shift_ir  = tck_rise && state == shift_ir;
    wire do_update_ir = tck_fall && state == update_ir;

    always_ff @(posedge clk) begin
        if (rst) begin
            ir_shift  <= `INSTR_IDCODE;
            ir_active <= `INSTR_IDCODE;
        end else if (ce) begin
            if (in_tlr) begin
                ir_active <= `INSTR_IDCODE;
            end else if (do_update_ir) begin
                ir_active <= ir_shift;
            end
            if (do_cap_ir) begin
                ir_shift <= `IR_CAPTURE_VALUE;
            end else if (do_shift_ir) begin
                ir_shift <= {tdi_s2, ir_shift[`IR_WIDTH-1:1]};
            end
        end
    end

    // decode; every code not listed below falls through to bypass
    wire is_extest   = ir_active == `INSTR_EXTEST;
    wire is_sample_z = ir_active == `INSTR_SAMPLE_Z;
    wire is_preload  = ir_active == `INSTR_SAMPLE_PRE;
    wire sel_id      = ir_active == `INSTR_IDCODE;
    wire sel_bsr     = is_extest | is_sample_z | is_preload;
    wire sel_bypass  = ~sel_id & ~sel_bsr;

    wire dr_capture = tck_rise && state == capture_dr;
    wire dr_shift   = tck_rise && state == shift_dr;
    wire dr_update  = tck_fall && state == update_dr;

    // bypass and identification registers
    logic                 bypass_bit;
    logic [`ID_WIDTH-1:0] id_reg;

    always_ff @(posedge clk) begin
        if (rst) begin
            bypass_bit <= `BYPASS_CAPTURE;
            id_reg     <= '0;
        end else if (ce) begin
            if (sel_bypass && dr_capture) begin
                bypass_bit <= `BYPASS_CAPTURE;
            end else if (sel_bypass && dr_shift) begin
                bypass_bit <= tdi_s2;
            end
            if (sel_id && dr_capture) begin
                id_reg <= ID_VALUE;
            end else if (sel_id && dr_shift) begin
                id_reg <= {tdi_s2, id_reg[`ID_WIDTH-1:1]};
            end
        end
    end

    // boundary register; pins are sampled through the synchronisers,
    // so a capture during pin transitions is harmless but not repeatable
    logic               bsr_serial;
    logic [BSR_LEN-1:0] bsr_parallel;

    boundary_cells #(
        .WIDTH    (BSR_LEN),
        .PIN_MASK (PIN_MASK),
        .DEFAULTS (DEFAULTS)
    ) cells (
        .clk          (clk),
        .rst          (rst),
        .ce           (ce),
        .capture      (sel_bsr && dr_capture),
        .shift        (sel_bsr && dr_shift),
        .update       (dr_update),
        .tdi          (tdi_s2),
        .pins         (pin_s2),
        .serial_out   (bsr_serial),
        .parallel_out (bsr_parallel)
    );

    // serial output mux
    wire in_shift  = state == shift_ir || state == shift_dr;
    wire dr_serial = sel_id ? id_reg[0] : (sel_bsr ? bsr_serial : bypass_bit);
    wire next_tdo  = (state == shift_ir) ? ir_shift[0] : dr_serial;

    always_ff @(posedge clk) begin
        if (rst) begin
            tdo      <= 1'b0;
            tdo_oe_n <= 1'b1;
        end else if (ce && tck_fall) begin
            tdo      <= next_tdo;
            tdo_oe_n <= ~in_shift;
        end
    end

    // pin control; inputs are only observed, never blocked
    wire   next_drive = is_extest;
    wire   next_float = is_sample_z;

    always_ff @(posedge clk) begin
        if (rst) begin
            pin_out      <= '0;
            pin_drive    <= 1'b0;
            pin_float    <= 1'b0;
            active_instr <= `INSTR_IDCODE;
        end else if (ce) begin
            pin_out      <= bsr_parallel;
            pin_drive    <= next_drive;
            pin_float    <= next_float;
            active_instr <= ir_active;
        end
    end

endmodule : sram_tap_instruction_logic

// >>> sram_tap_defs.svh
// constants for the scan port instruction logic
`ifndef SRAM_TAP_DEFS_SVH
`define SRAM_TAP_DEFS_SVH

`define IR_WIDTH            3
`define IR_CAPTURE_VALUE    3'h1
`define INSTR_EXTEST        3'h0
`define INSTR_IDCODE        3'h1
`define INSTR_SAMPLE_Z      3'h2
`define INSTR_RESERVED_LO   3'h3
`define INSTR_SAMPLE_PRE    3'h4
`define INSTR_PRIVATE       3'h5
`define INSTR_RESERVED_HI   3'h6
`define INSTR_BYPASS        3'h7
`define ID_WIDTH            32
`define BYPASS_CAPTURE      1'h0

`endif

// >>> sram_tap_pkg.sv
// types shared by the scan port instruction logic
package sram_tap_pkg;

    typedef enum logic [3:0] {
        test_logic_reset,
        run_test_idle,
        select_dr,
        capture_dr,
        shift_dr,
        exit1_dr,
        pause_dr,
        exit2_dr,
        update_dr,
        select_ir,
        capture_ir,
        shift_ir,
        exit1_ir,
        pause_ir,
        exit2_ir,
        update_ir
    } tap_state_type;

endpackage : sram_tap_pkg

// >>> boundary_cells.sv
// boundary scan register: capture, serial shift and parallel update latch
`timescale 1ns/100ps
module boundary_cells #(
    parameter int               WIDTH    = 8,
    parameter logic [WIDTH-1:0] PIN_MASK = {WIDTH{1'b1}},
    parameter logic [WIDTH-1:0] DEFAULTS = {WIDTH{1'b1}}
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             ce,
    input  wire logic             capture,
    input  wire logic             shift,
    input  wire logic             update,
    input  wire logic             tdi,
    input  wire logic [WIDTH-1:0] pins,
    output logic                  serial_out,
    output logic      [WIDTH-1:0] parallel_out
);

    logic [WIDTH-1:0] cells;
    wire  [WIDTH-1:0] captured = (pins & PIN_MASK) | (DEFAULTS & ~PIN_MASK);

    assign serial_out = cells[0];

    always_ff @(posedge clk) begin
        if (rst) begin
            cells        <= '0;
            parallel_out <= '0;
        end else if (ce) begin
            if (capture) begin
                cells <= captured;
            end else if (shift) begin
                cells <= {tdi, cells[WIDTH-1:1]};
            end
            if (update) begin
                parallel_out <= cells;
            end
        end
    end

endmodule : boundary_cells

// >>> sram_tap_monitor.sv
// assertion checker for the scan port instruction logic
`timescale 1ns/100ps
`include "sram_tap_defs.svh"
module sram_tap_monitor #(
    parameter int BSR_LEN = 8
) (
    input wire logic                 clk,
    input wire logic                 rst,
    input wire logic                 ce,
    input wire logic                 tck,
    input wire logic                 tms,
    input wire logic                 tdo,
    input wire logic                 tdo_oe_n,
    input wire logic [BSR_LEN-1:0]   pin_out,
    input wire logic                 pin_drive,
    input wire logic                 pin_float,
    input wire logic [`IR_WIDTH-1:0] active_instr
);
    // same two-stage sampling as the design, so edge moments line up
    logic [2:0] ck;
    logic [1:0] ms;
    logic [2:0] ones;
    wire        rise = ck[1] & ~ck[2];
    always_ff @(posedge clk) begin
        ck <= {ck[1:0], tck};
        ms <= {ms[0], tms};
        if (rst) begin
            ones <= 3'h0;
        end else if (rise) begin
            ones <= ms[1] ? ones + {2'h0, ones != 3'h7} : 3'h0;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    chk_reset_state:
        assert property (disable iff (1'b0) rst && ce |=> active_instr == `INSTR_IDCODE
            && !pin_drive && !pin_float && tdo_oe_n) else $error("reset state wrong");
    chk_extest_drive:
        assert property (pin_drive == (active_instr == `INSTR_EXTEST)) else $error("drive bad");
    chk_samplez_float:
        assert property (pin_float == (active_instr == `INSTR_SAMPLE_Z)) else $error("float bad");
    chk_instr_at_fall:
        assert property ($changed(active_instr) && active_instr != `INSTR_IDCODE |-> !ck[1])
            else $error("instruction changed outside tck low");
    chk_tdo_at_fall:
        assert property ($changed(tdo) |-> !ck[1] && !ck[2]) else $error("tdo moved early");
    chk_oe_at_fall:
        assert property ($changed(tdo_oe_n) |-> !ck[1]) else $error("tdo enable moved early");
    chk_pins_at_fall:
        assert property ($changed(pin_out) |-> !ck[1]) else $error("pin_out moved early");
    chk_ce_freeze:
        assert property (!ce |=> $stable(active_instr) && $stable(tdo) && $stable(tdo_oe_n)
            && $stable(pin_out) && $stable(pin_drive) && $stable(pin_float))
            else $error("output moved with clock enable low");
    chk_tms_reset:
        assert property (rise && ms[1] && ones == 3'h4 |-> ##[1:8]
            active_instr == `INSTR_IDCODE && !pin_drive) else $error("tms reset missed");
endmodule : sram_tap_monitor

bind sram_tap_instruction_logic sram_tap_monitor #(.BSR_LEN(BSR_LEN)) i_sram_tap_monitor (
    .clk(clk), .rst(rst), .ce(ce), .tck(tck), .tms(tms), .tdo(tdo), .tdo_oe_n(tdo_oe_n),
    .pin_out(pin_out), .pin_drive(pin_drive), .pin_float(pin_float),
    .active_instr(active_instr));

// >>> scan_controller.sv
// board scan controller model driving the test port pins
`timescale 1ns/100ps
module scan_controller (
    output logic      tck,
    output logic      tms,
    output logic      tdi,
    input  wire logic tdo,
    input  wire logic tdo_oe_n
);
    // tck stands low between frames; released tms and tdi float to the pull-up
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b1;
    end
    task automatic step(input logic m, input logic d, output logic q);
        tms = m;
        tdi = d;
        #62.5;
        // a released tdo reads inverted, so a missing enable shows as bad data
        q   = tdo_oe_n ? ~tdo : tdo;
        tck = 1'b1;
        #62.5;
        tck = 1'b0;
    endtask : step
    task automatic tap_reset();
        logic q;
        repeat (5) step(1'b1, 1'b1, q);
        step(1'b0, 1'b1, q);
    endtask : tap_reset
    // idle to shift, n bits lsb first, then update and back to idle
    task automatic scan(input logic ir, input int n, input logic [63:0] din,
                        output logic [63:0] dout);
        logic q;
        dout = '0;
        step(1'b1, 1'b1, q);
        if (ir) step(1'b1, 1'b1, q);
        step(1'b0, 1'b1, q);
        step(1'b0, 1'b1, q);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], q);
            dout[i] = q;
        end
        step(1'b1, 1'b1, q);
        step(1'b0, 1'b1, q);
        tms = 1'b1;
        tdi = 1'b1;
        #62.5;
    endtask : scan
endmodule : scan_controller

// >>> sram_tap_instruction_logic_test.sv
// self-checking bench for the scan port instruction logic
`timescale 1ns/100ps
`include "sram_tap_defs.svh"
module sram_tap_instruction_logic_test;
    localparam logic [31:0] ID = 32'h5a3c_0f01; // arbitrary value
    logic        clk, rst, ce, tck, tms, tdi, tdo, tdo_oe_n, pin_drive, pin_float;
    logic [7:0]  pin_in, pin_out, lfsr, exp_pins;
    logic [2:0]  active_instr;
    logic [63:0] din, dout, cap;
    int          err_count, check_count, n, code;
    // reserved codes are loaded only to prove that they act as bypass
    int          order[$] = '{1, 4, 0, 5, 6, 7, 2, 3, 0};
    sram_tap_instruction_logic #(.BSR_LEN(8), .PIN_MASK(8'h3f), .DEFAULTS(8'hff),
        .ID_VALUE(ID)) i_sram_tap_instruction_logic (.clk(clk), .rst(rst), .ce(ce),
        .tck(tck), .tms(tms), .tdi(tdi), .pin_in(pin_in), .tdo(tdo), .tdo_oe_n(tdo_oe_n),
        .pin_out(pin_out), .pin_drive(pin_drive), .pin_float(pin_float),
        .active_instr(active_instr));
    scan_controller i_scan_controller (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
        .tdo_oe_n(tdo_oe_n));
    function automatic logic [7:0] next_rand(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction : next_rand
    task automatic check(input logic [63:0] seen, input logic [63:0] want);
        check_count++;
        if (seen !== want) begin
            err_count++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask : check
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : report_and_stop
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        #500us;
        err_count++;
        report_and_stop();
    end
    initial begin
        rst = 1'b1;
        ce = 1'b1;
        pin_in = 8'h00;
        lfsr = 8'h5f;
        exp_pins = '0;
        err_count = 0;
        check_count = 0;
        repeat (16) @(negedge clk);
        rst = 1'b0;
        check(active_instr, `INSTR_IDCODE);
        i_scan_controller.tap_reset();
        foreach (order[k]) begin
            code = order[k];
            // first pass reads the power-up instruction without loading one
            if (k > 0) begin
                i_scan_controller.scan(1'b1, 3, {61'h0, code[2:0]}, dout);
                check(dout, `IR_CAPTURE_VALUE);
                check(active_instr, code[2:0]);
                check({pin_drive, pin_float}, {code == 0, code == 2});
                if (code == 0) check(pin_out, exp_pins);
            end
            @(negedge clk);
            lfsr = next_rand(lfsr);
            pin_in = lfsr;
            for (int i = 0; i < 8; i++) begin
                lfsr = next_rand(lfsr);
                din[i*8 +: 8] = lfsr;
            end
            n = (code == 1) ? 32 : (code inside {0, 2, 4}) ? 8 : 1;
            cap = (n == 32) ? {32'h0, ID} : (n == 8) ? {56'h0, pin_in & 8'h3f | 8'hc0} : '0;
            i_scan_controller.scan(1'b0, 40, din, dout);
            check(dout, ((din << n) | cap) & 64'hff_ffff_ffff);
            if (n == 8) exp_pins = din[39:32];
            if (code == 0) check(pin_out, exp_pins);
            $display("test code %0d done", code);
        end
        @(negedge clk);
        ce = 1'b0;
        pin_in = ~pin_in;
        repeat (20) @(negedge clk);
        ce = 1'b1;
        check(active_instr, `INSTR_EXTEST);
        check(pin_out, exp_pins);
        $display("test clock enable done");
        i_scan_controller.tap_reset();
        check(tdo_oe_n, 1'b1);
        check(active_instr, `INSTR_IDCODE);
        check({pin_drive, pin_float}, 2'b00);
        $display("test tms reset done");
        report_and_stop();
    end
endmodule : sram_tap_instruction_logic_test
